// >>> verilog/crp_pkg.sv
// Constants shared by the offset, protection and power-state command bank
package crp_pkg;
  // Command codes
  localparam logic [7:0]  CMD_OFFSET      = 8'h39;
  localparam logic [7:0]  CMD_PROTECT     = 8'h3A;
  localparam logic [7:0]  CMD_FORCE       = 8'h3B;
  // Offset command layout
  localparam logic [5:0]  OFF_EXPONENT    = 6'h3C;
  localparam int          OFF_MANT_W      = 7;
  localparam logic [6:0]  OFF_MANT_RST    = 7'h00;
  // Protection select layout
  localparam int          PROT_W          = 11;
  localparam logic [10:0] PROT_RST        = 11'h000;
  localparam int          PB_PWM_CHECK    = 10;
  localparam int          PB_CS_FAULT     = 9;
  localparam int          PB_TEMP_FAULT   = 8;
  localparam int          PB_TEMP_BLOCK   = 7;
  localparam int          PB_TRANS_MASK   = 6;
  localparam int          PB_VIN_HI       = 5;
  localparam int          PB_VIN_LO       = 4;
  localparam int          PB_OVER_HI      = 3;
  localparam int          PB_OVER_LO      = 2;
  localparam int          PB_OTP_HI       = 1;
  localparam int          PB_OTP_LO       = 0;
  localparam logic [1:0]  VIN_OFF_CODE    = 2'h3;
  localparam logic [1:0]  OVER_OFF_CODE   = 2'h1;
  localparam logic [1:0]  OTP_OFF_CODE    = 2'h1;
  // Power-state force layout
  localparam logic [15:0] FORCE_WMASK     = 16'hD9BF;
  localparam logic [15:0] FORCE_RSET      = 16'h0640;
  localparam logic [15:0] FORCE_RST       = 16'h0000;
  localparam int          FB_FOLLOW       = 15;
  localparam int          FB_TRI_MID      = 14;
  localparam int          FB_SUPPLY_SEL   = 12;
  localparam int          FB_MASTER_OFF   = 11;
  localparam int          FB_ONTIME_UPD   = 8;
  localparam int          FB_DLL          = 7;
  localparam int          FB_AMP_INST     = 5;
  localparam int          FB_DELAY_HI     = 4;
  localparam int          FB_DELAY_LO     = 0;
  // Timing
  localparam int          CLK_PERIOD_PS   = 40000;
  localparam int          TRI_STEP_PS     = 5000;
  localparam int          PWM_CHECK_CYC   = 16;
  localparam int          SUPPLY_W        = 12;

  // Whole clock cycles covering a tri-state low interval, rounded up
  function automatic logic [4:0] crp_low_cycles(input logic [4:0] code);
    int ps;
    ps = int'(code) * TRI_STEP_PS;
    return 5'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : crp_low_cycles
endpackage : crp_pkg

// >>> verilog/crp_tri_seq.sv
// PWM high to tri-state sequencer with inserted low interval
`timescale 1ns/1ps
module crp_tri_seq (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Control
  input  wire logic       i_mode_mid,
  input  wire logic [4:0] i_delay_code,
  input  wire logic       i_pwm_high,
  input  wire logic       i_enter_tri,
  // PWM state
  output logic            o_drive_low,
  output logic            o_tri_hiz,
  output logic            o_tri_mid
);
  typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_TRI} crp_tri_state_t;

  crp_tri_state_t state_reg, state_next;
  logic [4:0]     cnt_reg, cnt_next;
  logic [4:0]     low_cyc;

  always_comb begin
    low_cyc    = crp_pkg::crp_low_cycles(i_delay_code);
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (i_enter_tri && i_pwm_high && i_mode_mid && (low_cyc != 5'h00)) begin
          state_next = ST_LOW;
          cnt_next   = low_cyc - 5'h01;
        end else if (i_enter_tri) begin
          state_next = ST_TRI;
        end
      end
      ST_LOW: begin
        if (cnt_reg == 5'h00) begin
          state_next = ST_TRI;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      ST_TRI: begin
        if (!i_enter_tri) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_RUN;
      cnt_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign o_drive_low = (state_reg == ST_LOW);
  assign o_tri_hiz   = (state_reg == ST_TRI) && !i_mode_mid;
  assign o_tri_mid   = (state_reg == ST_TRI) && i_mode_mid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_low_before_mid;
    (state_reg == ST_RUN) && i_enter_tri && i_pwm_high && i_mode_mid && (i_delay_code == 5'h10)
      |=> o_drive_low [*2] ##1 (state_reg == ST_TRI);
  endproperty
  a_low_before_mid: assert property (p_low_before_mid)
    else $error("Low interval length wrong before middle level");
endmodule : crp_tri_seq

// >>> verilog/crp_supply_sel.sv
// Supply value selection and on-time refresh strobe
`timescale 1ns/1ps
module crp_supply_sel #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Control
  input  wire logic         i_use_latched,
  input  wire logic         i_update_en,
  input  wire logic [W-1:0] i_live,
  // Results
  output logic [W-1:0]      o_value,
  output logic              o_update
);
  logic [W-1:0] latched_reg, latched_next;
  logic         update_reg, update_next;

  always_comb begin
    latched_next = latched_reg;
    update_next  = 1'b0;
    if (i_update_en && (i_live != latched_reg)) begin
      latched_next = i_live;
      update_next  = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      latched_reg <= '0;
      update_reg  <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      update_reg  <= update_next;
    end
  end

  assign o_value  = i_use_latched ? latched_reg : i_live;
  assign o_update = update_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_no_update_off;
    !i_update_en |=> !o_update;
  endproperty
  a_no_update_off: assert property (p_no_update_off)
    else $error("On-time refresh while refresh disabled");
endmodule : crp_supply_sel

// >>> verilog/crp_regs.sv
// Offset, protection-select and power-state force command bank
`timescale 1ns/1ps

// Notes on behaviour
// - offset exponent always reads 111100
// - offset mantissa signed, scaled by resolution
// - listed reserved bits ignore writes, read zero
// - force bits 10:9 always read 11
// - force bit 6 always reads one
// - pulse check after fault holds PWM Hi-Z
// - low phase sense latches fault when enabled
// - thermal sense fault latches when enabled
// - bit 7 low lets thermal fault block overheat
// - transition may mask first overvolt guard
// - input guard off only for code 11
// - first overvolt off only for code 01
// - overheat guard off only for code 01
// - phase count follows input in soft start and transition only when set
// - tri-state style Hi-Z or middle level
// - on-time uses live or latched supply
// - master bit disables every protection
// - on-time refresh on supply change when enabled
// - delay-locked loop enable output
// - report averaged or instantaneous current
// - low interval before middle tri-state level
module crp_regs #(
  parameter int SUPPLY_W  = crp_pkg::SUPPLY_W,
  parameter int CHECK_CYC = crp_pkg::PWM_CHECK_CYC
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // Command port
  input  wire logic [7:0]          i_cmd_code,
  input  wire logic                i_cmd_wr,
  input  wire logic                i_cmd_rd,
  input  wire logic [15:0]         i_cmd_wdata,
  output logic      [15:0]         o_cmd_rdata,
  output logic                     o_cmd_ack,
  output logic                     o_cmd_nak,
  // Regulator status
  input  wire logic                i_amp_resolution,
  input  wire logic                i_soft_start,
  input  wire logic                i_voltage_transition,
  input  wire logic                i_power_state_input,
  input  wire logic                i_phase_sense_low,
  input  wire logic                i_thermal_sense_high,
  input  wire logic                i_overheat,
  input  wire logic                i_input_fault,
  input  wire logic                i_overvolt,
  input  wire logic                i_pwm_high,
  input  wire logic                i_enter_tri,
  input  wire logic [SUPPLY_W-1:0] i_supply_live,
  input  wire logic [15:0]         i_amp_avg,
  input  wire logic [15:0]         i_amp_inst,
  // Regulator control
  output logic                     o_low_phase,
  output logic                     o_input_guard_en,
  output logic                     o_overvolt_en,
  output logic                     o_overheat_en,
  output logic                     o_fault_latched,
  output logic                     o_pwm_check,
  output logic                     o_pwm_hiz,
  output logic                     o_pwm_mid,
  output logic                     o_pwm_low,
  output logic [SUPPLY_W-1:0]      o_supply_value,
  output logic                     o_ontime_update,
  output logic                     o_dll_en,
  output logic [15:0]              o_amp_report
);
  // Command registers
  logic [6:0]  off_mant_reg, off_mant_next;
  logic [10:0] prot_reg, prot_next;
  logic [15:0] force_reg, force_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next, nak_reg, nak_next;
  logic [15:0] off_word, prot_word, force_word;

  always_comb begin
    off_word   = {crp_pkg::OFF_EXPONENT, 3'h0, off_mant_reg};
    prot_word  = {5'h00, prot_reg};
    force_word = (force_reg & crp_pkg::FORCE_WMASK) | crp_pkg::FORCE_RSET;
    off_mant_next = off_mant_reg;
    prot_next     = prot_reg;
    force_next    = force_reg;
    rdata_next    = rdata_reg;
    ack_next      = 1'b0;
    nak_next      = 1'b0;
    if (i_cmd_wr || i_cmd_rd) begin
      ack_next = 1'b1;
      case (i_cmd_code)
        crp_pkg::CMD_OFFSET:  rdata_next = off_word;
        crp_pkg::CMD_PROTECT: rdata_next = prot_word;
        crp_pkg::CMD_FORCE:   rdata_next = force_word;
        default: begin
          rdata_next = 16'h0000;
          ack_next   = 1'b0;
          nak_next   = 1'b1;
        end
      endcase
    end
    if (i_cmd_wr) begin
      case (i_cmd_code)
        crp_pkg::CMD_OFFSET:  off_mant_next = i_cmd_wdata[6:0];
        crp_pkg::CMD_PROTECT: prot_next     = i_cmd_wdata[10:0];
        crp_pkg::CMD_FORCE:   force_next    = i_cmd_wdata & crp_pkg::FORCE_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      off_mant_reg <= crp_pkg::OFF_MANT_RST;
      prot_reg     <= crp_pkg::PROT_RST;
      force_reg    <= crp_pkg::FORCE_RST;
      rdata_reg    <= 16'h0000;
      ack_reg      <= 1'b0;
      nak_reg      <= 1'b0;
    end else begin
      off_mant_reg <= off_mant_next;
      prot_reg     <= prot_next;
      force_reg    <= force_next;
      rdata_reg    <= rdata_next;
      ack_reg      <= ack_next;
      nak_reg      <= nak_next;
    end
  end

  // Field views
  logic master_guard_off, pulse_check_after_fault, transition_masks_overvolt;
  logic input_guard_off, first_overvolt_off, overheat_guard_off;
  always_comb begin
    master_guard_off          = force_reg[crp_pkg::FB_MASTER_OFF];
    pulse_check_after_fault   = prot_reg[crp_pkg::PB_PWM_CHECK];
    transition_masks_overvolt = prot_reg[crp_pkg::PB_TRANS_MASK];
    input_guard_off    = prot_reg[crp_pkg::PB_VIN_HI:crp_pkg::PB_VIN_LO]
                         == crp_pkg::VIN_OFF_CODE;
    first_overvolt_off = prot_reg[crp_pkg::PB_OVER_HI:crp_pkg::PB_OVER_LO]
                         == crp_pkg::OVER_OFF_CODE;
    overheat_guard_off = prot_reg[crp_pkg::PB_OTP_HI:crp_pkg::PB_OTP_LO]
                         == crp_pkg::OTP_OFF_CODE;
  end

  // Protection state
  logic       temp_fault_reg, temp_fault_next;
  logic       fault_reg, fault_next;
  logic       check_reg, check_next;
  logic [7:0] check_cnt_reg, check_cnt_next;
  logic       low_phase_reg, low_phase_next;
  logic       vin_en_reg, vin_en_next, ovp_en_reg, ovp_en_next, otp_en_reg, otp_en_next;
  logic       trip;

  always_comb begin
    vin_en_next = !master_guard_off && !input_guard_off;
    ovp_en_next = !master_guard_off && !first_overvolt_off
                  && !(transition_masks_overvolt && i_voltage_transition);
    // Bit 7 clear lets a caught thermal-sense fault mask overheat
    otp_en_next = !master_guard_off && !overheat_guard_off
                  && !(temp_fault_reg && !prot_reg[crp_pkg::PB_TEMP_BLOCK]);
    temp_fault_next = temp_fault_reg || (!master_guard_off
                      && prot_reg[crp_pkg::PB_TEMP_FAULT] && i_thermal_sense_high);
    trip = !master_guard_off && (
             (prot_reg[crp_pkg::PB_CS_FAULT] && i_phase_sense_low)
           || (prot_reg[crp_pkg::PB_TEMP_FAULT] && i_thermal_sense_high)
           || (vin_en_reg && i_input_fault)
           || (ovp_en_reg && i_overvolt)
           || (otp_en_reg && i_overheat));
    // Latch-off is released only by reset
    fault_next     = fault_reg || trip;
    check_next     = check_reg;
    check_cnt_next = check_cnt_reg;
    if (check_reg) begin
      if (check_cnt_reg == 8'h00) begin
        check_next = 1'b0;
      end else begin
        check_cnt_next = check_cnt_reg - 8'h01;
      end
    end else if (trip && !fault_reg && pulse_check_after_fault) begin
      check_next     = 1'b1;
      check_cnt_next = 8'(CHECK_CYC - 1);
    end
    low_phase_next = !i_power_state_input && (force_reg[crp_pkg::FB_FOLLOW]
                     || !(i_soft_start || i_voltage_transition));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_fault_reg <= 1'b0;
      fault_reg      <= 1'b0;
      check_reg      <= 1'b0;
      check_cnt_reg  <= 8'h00;
      low_phase_reg  <= 1'b0;
      vin_en_reg     <= 1'b0;
      ovp_en_reg     <= 1'b0;
      otp_en_reg     <= 1'b0;
    end else begin
      temp_fault_reg <= temp_fault_next;
      fault_reg      <= fault_next;
      check_reg      <= check_next;
      check_cnt_reg  <= check_cnt_next;
      low_phase_reg  <= low_phase_next;
      vin_en_reg     <= vin_en_next;
      ovp_en_reg     <= ovp_en_next;
      otp_en_reg     <= otp_en_next;
    end
  end

  // Tri-state sequencing and supply selection
  logic tri_low, tri_hiz, tri_mid;
  logic [SUPPLY_W-1:0] supply_val;
  logic supply_upd;

  crp_tri_seq u_tri (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_mode_mid   (force_reg[crp_pkg::FB_TRI_MID]),
    .i_delay_code (force_reg[crp_pkg::FB_DELAY_HI:crp_pkg::FB_DELAY_LO]),
    .i_pwm_high   (i_pwm_high),
    .i_enter_tri  (i_enter_tri),
    .o_drive_low  (tri_low),
    .o_tri_hiz    (tri_hiz),
    .o_tri_mid    (tri_mid)
  );

  crp_supply_sel #(.W(SUPPLY_W)) u_supply (
    .i_clk         (i_clk),
    .i_rst_b       (i_rst_b),
    .i_use_latched (force_reg[crp_pkg::FB_SUPPLY_SEL]),
    .i_update_en   (force_reg[crp_pkg::FB_ONTIME_UPD]),
    .i_live        (i_supply_live),
    .o_value       (supply_val),
    .o_update      (supply_upd)
  );

  // Output stage
  logic        hiz_reg, hiz_next, mid_reg, mid_next, low_reg, low_next;
  logic [SUPPLY_W-1:0] sup_reg;
  logic        upd_reg, dll_reg, dll_next;
  logic [15:0] report_reg, report_next, offset_q;

  always_comb begin
    // Check window overrides any tri-state style
    hiz_next = check_reg || tri_hiz;
    mid_next = tri_mid && !check_reg;
    low_next = tri_low && !check_reg;
    dll_next = force_reg[crp_pkg::FB_DLL];
    offset_q = i_amp_resolution ? {{8{off_mant_reg[6]}}, off_mant_reg, 1'b0}
                                : {{9{off_mant_reg[6]}}, off_mant_reg};
    report_next = (force_reg[crp_pkg::FB_AMP_INST] ? i_amp_inst : i_amp_avg)
                  + offset_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hiz_reg    <= 1'b0;
      mid_reg    <= 1'b0;
      low_reg    <= 1'b0;
      sup_reg    <= '0;
      upd_reg    <= 1'b0;
      dll_reg    <= 1'b0;
      report_reg <= 16'h0000;
    end else begin
      hiz_reg    <= hiz_next;
      mid_reg    <= mid_next;
      low_reg    <= low_next;
      sup_reg    <= supply_val;
      upd_reg    <= supply_upd;
      dll_reg    <= dll_next;
      report_reg <= report_next;
    end
  end

  assign o_cmd_rdata      = rdata_reg;
  assign o_cmd_ack        = ack_reg;
  assign o_cmd_nak        = nak_reg;
  assign o_low_phase      = low_phase_reg;
  assign o_input_guard_en = vin_en_reg;
  assign o_overvolt_en    = ovp_en_reg;
  assign o_overheat_en    = otp_en_reg;
  assign o_fault_latched  = fault_reg;
  assign o_pwm_check      = check_reg;
  assign o_pwm_hiz        = hiz_reg;
  assign o_pwm_mid        = mid_reg;
  assign o_pwm_low        = low_reg;
  assign o_supply_value   = sup_reg;
  assign o_ontime_update  = upd_reg;
  assign o_dll_en         = dll_reg;
  assign o_amp_report     = report_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_offset_exp;
    i_cmd_rd && (i_cmd_code == crp_pkg::CMD_OFFSET)
      |=> o_cmd_ack && (o_cmd_rdata[15:7] == 9'h1E0);
  endproperty
  a_offset_exp: assert property (p_offset_exp)
    else $error("Offset exponent or reserved bits wrong");

  property p_force_fixed;
    i_cmd_rd && (i_cmd_code == crp_pkg::CMD_FORCE)
      |=> (o_cmd_rdata[13] == 1'b0) && (o_cmd_rdata[10:9] == 2'h3) && o_cmd_rdata[6];
  endproperty
  a_force_fixed: assert property (p_force_fixed)
    else $error("Force command fixed bits wrong");

  property p_prot_reserved;
    i_cmd_rd && (i_cmd_code == crp_pkg::CMD_PROTECT) |=> o_cmd_rdata[15:11] == 5'h00;
  endproperty
  a_prot_reserved: assert property (p_prot_reserved)
    else $error("Protection reserved bits not zero");

  property p_check_hiz;
    o_pwm_check |=> o_pwm_hiz;
  endproperty
  a_check_hiz: assert property (p_check_hiz)
    else $error("PWM not Hi-Z during pulse check");

  property p_cs_latch;
    !master_guard_off && prot_reg[crp_pkg::PB_CS_FAULT] && i_phase_sense_low
      |=> o_fault_latched [*2];
  endproperty
  a_cs_latch: assert property (p_cs_latch)
    else $error("Phase sense fault did not latch");

  property p_temp_latch;
    !master_guard_off && prot_reg[crp_pkg::PB_TEMP_FAULT] && i_thermal_sense_high
      |=> o_fault_latched && temp_fault_reg;
  endproperty
  a_temp_latch: assert property (p_temp_latch)
    else $error("Thermal sense fault did not latch");

  property p_temp_block;
    temp_fault_reg && !prot_reg[crp_pkg::PB_TEMP_BLOCK] |=> !o_overheat_en;
  endproperty
  a_temp_block: assert property (p_temp_block)
    else $error("Overheat guard not blocked by thermal fault");

  property p_voltage_transition_mask;
    transition_masks_overvolt && i_voltage_transition |=> !o_overvolt_en;
  endproperty
  a_voltage_transition_mask: assert property (p_voltage_transition_mask)
    else $error("First overvolt guard active during transition");

  property p_vin_code;
    !master_guard_off && (prot_reg[5:4] != 2'h3) |=> o_input_guard_en;
  endproperty
  a_vin_code: assert property (p_vin_code)
    else $error("Input guard disabled by wrong code");

  property p_otp_code;
    (prot_reg[1:0] == 2'h1) |=> !o_overheat_en;
  endproperty
  a_otp_code: assert property (p_otp_code)
    else $error("Overheat guard not disabled by code 01");

  property p_master;
    master_guard_off && $stable(force_reg) |=> !o_input_guard_en && !o_overvolt_en
      && !o_overheat_en && $stable(o_fault_latched);
  endproperty
  a_master: assert property (p_master)
    else $error("Protection active under master disable");

  property p_phase_full;
    !force_reg[crp_pkg::FB_FOLLOW] && i_soft_start |=> !o_low_phase;
  endproperty
  a_phase_full: assert property (p_phase_full)
    else $error("Reduced phases during soft start");

  property p_report_inst;
    force_reg[crp_pkg::FB_AMP_INST] && (off_mant_reg == 7'h00) |=> o_amp_report == $past(i_amp_inst);
  endproperty
  a_report_inst: assert property (p_report_inst)
    else $error("Instantaneous report mismatch");
endmodule : crp_regs

// >>> test/crp_host_model.sv
// Host model issuing command reads and writes
`timescale 1ns/1ps
module crp_host_model (
  // Clock
  input  wire logic        i_clk,
  // Command port
  output logic [7:0]       o_cmd_code,
  output logic             o_cmd_wr,
  output logic             o_cmd_rd,
  output logic [15:0]      o_cmd_wdata,
  input  wire logic [15:0] i_cmd_rdata,
  input  wire logic        i_cmd_ack,
  input  wire logic        i_cmd_nak
);
  initial begin
    o_cmd_code  = 8'h00;
    o_cmd_wr    = 1'b0;
    o_cmd_rd    = 1'b0;
    o_cmd_wdata = 16'h0000;
  end

  // One-cycle request; gain setup stays with the host
  task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] r);
    o_cmd_code  <= c;
    o_cmd_wr    <= w;
    o_cmd_rd    <= ~w;
    o_cmd_wdata <= d;
    @(posedge i_clk);
    o_cmd_wr    <= 1'b0;
    o_cmd_rd    <= 1'b0;
    // Stale data would hide a late sample
    o_cmd_wdata <= ~d;
    @(posedge i_clk);
    q = i_cmd_rdata;
    r = {i_cmd_nak, i_cmd_ack};
  endtask : access
endmodule : crp_host_model

// >>> test/crp_regs_tb.sv
// Self-checking bench for the command bank
`timescale 1ns/1ps
module crp_regs_tb;
  logic        i_clk;
  logic        i_rst_b;
  logic [7:0]  code;
  logic        wr;
  logic        rd;
  logic [15:0] wd;
  logic [15:0] rq;
  logic        ack;
  logic        nak;
  logic [10:0] st;
  logic [11:0] sup;
  logic [11:0] supv;
  logic [15:0] avg;
  logic [15:0] inst;
  logic [15:0] rep;
  logic [10:0] ctl;
  int          fail_count;
  int          checks_done;
  int          n;
  logic [15:0] pv [6] = '{16'h0030, 16'h0020, 16'h0004, 16'h0008, 16'h0001, 16'h0002};
  logic [2:0]  ge [6] = '{3'b110, 3'b111, 3'b101, 3'b111, 3'b011, 3'b111};

  crp_host_model u_host (.i_clk(i_clk), .o_cmd_code(code), .o_cmd_wr(wr), .o_cmd_rd(rd),
    .o_cmd_wdata(wd), .i_cmd_rdata(rq), .i_cmd_ack(ack), .i_cmd_nak(nak));

  crp_regs #(.CHECK_CYC(4)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_code(code),
    .i_cmd_wr(wr), .i_cmd_rd(rd), .i_cmd_wdata(wd), .o_cmd_rdata(rq), .o_cmd_ack(ack),
    .o_cmd_nak(nak), .i_amp_resolution(st[0]), .i_soft_start(st[1]),
    .i_voltage_transition(st[2]), .i_power_state_input(st[3]), .i_phase_sense_low(st[4]),
    .i_thermal_sense_high(st[5]), .i_overheat(st[6]), .i_input_fault(st[7]),
    .i_overvolt(st[8]), .i_pwm_high(st[9]), .i_enter_tri(st[10]), .i_supply_live(sup),
    .i_amp_avg(avg), .i_amp_inst(inst), .o_low_phase(ctl[0]), .o_input_guard_en(ctl[1]),
    .o_overvolt_en(ctl[2]), .o_overheat_en(ctl[3]), .o_fault_latched(ctl[4]),
    .o_pwm_check(ctl[5]), .o_pwm_hiz(ctl[6]), .o_pwm_mid(ctl[7]), .o_pwm_low(ctl[8]),
    .o_supply_value(supv), .o_ontime_update(ctl[9]), .o_dll_en(ctl[10]),
    .o_amp_report(rep));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Read data is compared on reads only
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d,
                    input logic [15:0] e, input logic [1:0] r);
    logic [15:0] q;
    logic [1:0]  a;
    u_host.access(w, c, d, q, a);
    chk({14'h0, a}, {14'h0, r});
    if (!w) chk(q, e);
  endtask : rw

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask : tick

  task automatic cnt(input int b);
    n = 0;
    repeat (8) begin
      @(posedge i_clk);
      n += int'(ctl[b]);
    end
  endtask : cnt

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    fail_count = 0;
    checks_done = 0;
    i_rst_b = 1'b0;
    st = 11'h000;
    sup = 12'h100;
    avg = 16'h0010;
    inst = 16'h0040;
    tick(5);
    i_rst_b <= 1'b1;
    rw(0, crp_pkg::CMD_OFFSET, 0, 16'hF000, 1);
    rw(0, crp_pkg::CMD_FORCE, 0, 16'h0640, 1);
    rw(1, crp_pkg::CMD_OFFSET, 16'hFFFF, 0, 1);
    rw(0, crp_pkg::CMD_OFFSET, 0, 16'hF07F, 1);
    rw(1, crp_pkg::CMD_PROTECT, 16'hFFFF, 0, 1);
    rw(0, crp_pkg::CMD_PROTECT, 0, 16'h07FF, 1);
    rw(1, crp_pkg::CMD_FORCE, 16'hFFFF, 0, 1);
    rw(0, crp_pkg::CMD_FORCE, 0, 16'hDFFF, 1);
    rw(0, 8'h3C, 0, 16'h0000, 2'b10);
    $display("test readback done");
    rw(1, crp_pkg::CMD_FORCE, 16'h0000, 0, 1);
    foreach (pv[i]) begin
      rw(1, crp_pkg::CMD_PROTECT, pv[i], 0, 1);
      tick(4);
      chk({13'h0, ctl[3:1]}, {13'h0, ge[i]});
    end
    rw(1, crp_pkg::CMD_FORCE, 16'h0880, 0, 1);
    tick(4);
    chk({13'h0, ctl[3:1]}, 16'h0000);
    chk({15'h0, ctl[10]}, 16'h0001);
    st[1] <= 1'b1;
    rw(1, crp_pkg::CMD_FORCE, 16'h8000, 0, 1);
    tick(4);
    chk({15'h0, ctl[0]}, 16'h0001);
    rw(1, crp_pkg::CMD_FORCE, 16'h0000, 0, 1);
    tick(4);
    chk({15'h0, ctl[0]}, 16'h0000);
    $display("test guards done");
    rw(1, crp_pkg::CMD_OFFSET, 16'h007E, 0, 1);
    rw(1, crp_pkg::CMD_FORCE, 16'h0020, 0, 1);
    tick(4);
    chk(rep, 16'h003E);
    st[0] <= 1'b1;
    rw(1, crp_pkg::CMD_FORCE, 16'h0000, 0, 1);
    tick(4);
    chk(rep, 16'h000C);
    rw(1, crp_pkg::CMD_OFFSET, 16'h0000, 0, 1);
    rw(1, crp_pkg::CMD_FORCE, 16'h0020, 0, 1);
    tick(4);
    chk(rep, 16'h0040);
    $display("test report done");
    rw(1, crp_pkg::CMD_FORCE, 16'h0100, 0, 1);
    sup <= 12'h200;
    cnt(9);
    chk(16'(n), 16'h0001);
    chk({4'h0, supv}, 16'h0200);
    rw(1, crp_pkg::CMD_FORCE, 16'h1000, 0, 1);
    sup <= 12'h300;
    cnt(9);
    chk(16'(n), 16'h0000);
    chk({4'h0, supv}, 16'h0200);
    $display("test supply done");
    rw(1, crp_pkg::CMD_FORCE, 16'h4010, 0, 1);
    st[10:9] <= 2'b11;
    cnt(8);
    chk(16'(n), 16'h0002);
    chk({15'h0, ctl[7]}, 16'h0001);
    st[10] <= 1'b0;
    rw(1, crp_pkg::CMD_FORCE, 16'h0010, 0, 1);
    st[10] <= 1'b1;
    cnt(8);
    chk(16'(n), 16'h0000);
    chk({14'h0, ctl[7:6]}, 16'h0001);
    st[10] <= 1'b0;
    $display("test tristate done");
    rw(1, crp_pkg::CMD_PROTECT, 16'h0600, 0, 1);
    st[4] <= 1'b1;
    tick(4);
    chk({13'h0, ctl[6:4]}, 16'h0007);
    tick(6);
    chk({13'h0, ctl[6:4]}, 16'h0001);
    i_rst_b <= 1'b0;
    tick(2);
    i_rst_b <= 1'b1;
    tick(2);
    chk({15'h0, ctl[4]}, 16'h0000);
    $display("test fault done");
    st[2] <= 1'b1;
    rw(1, crp_pkg::CMD_PROTECT, 16'h0040, 0, 1);
    tick(4);
    chk({15'h0, ctl[2]}, 16'h0000);
    rw(1, crp_pkg::CMD_PROTECT, 16'h0100, 0, 1);
    st[5] <= 1'b1;
    tick(4);
    chk({13'h0, ctl[4:2]}, 16'h0005);
    rw(1, crp_pkg::CMD_PROTECT, 16'h0180, 0, 1);
    tick(4);
    chk({15'h0, ctl[3]}, 16'h0001);
    $display("test sense done");
    finish_test();
  end
endmodule : crp_regs_tb
